// *** common/camlink_regs.svh ***
// Summary of operation
// (RULE1) forward channel is sent as 28-bit frames; layout follows payload mode
// (RULE2) 12-bit low mode takes 12 data plus 2 sync bits, 25 to 50 MHz
// (RULE3) 12-bit high mode takes 12 data plus 2 sync bits, 37.5 to 75 MHz
// (RULE4) 10-bit mode takes 10 data plus 2 sync bits, 50 to 100 MHz
// (RULE5) imager toggles sync at most once per ten pixel clocks in 10-bit mode
// (RULE6) frame clock is pixel clock divided by 1, 1.5 or 2 per mode
// (RULE7) frame payload is scrambled and DC-balanced for AC coupling
// (RULE8) every frame carries a control-channel bit, independent of blanking
// (RULE9) every frame carries one parity bit for far-end error detection
// (RULE10) back-channel words are CRC-4 checked; errors counted in 8 bits
// (RULE11) the error count is readable at registers backchannel_crc_errors_a and backchannel_crc_errors_b; count sits at 0x0a only, 0x0b holds flags
// (RULE12) with pixel clock reference, aux outputs can mirror remote inputs
// (RULE13) external oscillator mode: aux 3 is clock input, aux 2 its half
// (RULE14) remote-to-local aux forwarding works up to 66 kHz
// (RULE15) capture bit 1 latches on rising pixel clock edge, 0 on falling
// (RULE16) power-down low disables link; serial outputs stay static high
// (RULE17) powered, fall back to internal oscillator on lost pixel clock
// (RULE18) forwarded aux edges reach outputs within 25 us
// (RULE19) capture edge select lives in bit 0 of register 0x03
// (RULE20) pixel clock edge with 0x03 bit 1 clear switches off internal osc
// (RULE21) parity covers all payload bits before scrambling, even sense
// (RULE22) error counter clears on lost lock or power-down and saturates
`ifndef CAMLINK_REGS_SVH
`define CAMLINK_REGS_SVH

// register indices on the plain register port
`define REG_CLK_CTRL  8'h03
`define REG_MODE      8'h05
`define REG_CTRL_TX   8'h06
`define REG_CTRL_RX   8'h07
`define REG_CRC_ERR_A 8'h0a
`define REG_CRC_ERR_B 8'h0b
`define REG_STATUS    8'h0c
`define REG_AUX_CFG   8'h0d

// field positions and reset values
`define BIT_EDGE      0
`define BIT_OSC_HOLD  1
`define BIT_EXT_OSC   2
`define BIT_ERR_SEEN  0
`define CLK_CTRL_RST  2'h1
`define MODE_RST      2'h0
`define CTRL_TX_RST   8'h00
`define AUX_CFG_RST   8'h0f
`define MODE_C_12LF   2'h0
`define MODE_C_12HF   2'h1
`define MODE_C_10B    2'h2

// frame layout
`define FRAME_W       28
`define PAY_W         24
`define F_INV         27
`define F_PAR         26
`define F_CTL         25
`define F_MARK        24
`define SCR_W         27
`define HALF_W        13
`define FRAME_IDLE    28'hfffffff
`define ACC_W         48
`define PAY_12LF      6'd14
`define PAY_12HF      6'd21
`define PAY_10B       6'd24
`define PIX_12_W      6'd14
`define PIX_10_W      6'd12
`define LFSR_SEED     16'hace1
`define CNT_MAX       8'hff

// back channel word: data then crc
`define BC_DATA_W     8
`define CRC_W         4
`define CRC_POLY      4'h3
`define BC_WORD_W     12

// timing
`define MCLK_NS       40
`define AUX_SKEW_NS   25000
`define AUX_SKEW_CYC  ((`AUX_SKEW_NS) / (`MCLK_NS))
`define AUX_RATE_HZ   66000
`define PCLK_LOSS_NS  640
`define PCLK_LOSS_CYC ((`PCLK_LOSS_NS + `MCLK_NS - 1) / (`MCLK_NS))
`define LOCK_EDGES    4
`define INT_OSC_DIV   2

`endif

// *** common/camlink_pkg.sv ***
package camlink_pkg;

    // clock source / link state
    typedef enum logic [1:0] {
        SRC_DOWN,
        SRC_INTERNAL,
        SRC_LOCKING,
        SRC_PIXEL
    } src_t;

    // payload modes
    typedef enum logic [1:0] {
        MODE_12LF,
        MODE_12HF,
        MODE_10B
    } mode_t;

endpackage

// *** src/bc_crc_check.sv ***
`timescale 1ns/1ps
`include "camlink_regs.svh"
module bc_crc_check #(
    parameter int DATA_W = `BC_DATA_W,
    parameter int CRC_W  = `CRC_W
) (
    input  wire logic                    clk_in,
    input  wire logic                    rst_in,
    input  wire logic [DATA_W+CRC_W-1:0] word_in,
    input  wire logic                    valid_in,
    output logic      [DATA_W-1:0]       data_out,
    output logic                         ok_out,
    output logic                         err_out
);

    // bitwise crc over the data field, msb first, zero start
    function automatic logic [CRC_W-1:0] crc_calc(input logic [DATA_W-1:0] d);
        logic [CRC_W-1:0] c;
        logic             fb;
        c  = '0;
        fb = 1'b0;
        for (int i = DATA_W - 1; i >= 0; i--) begin
            fb = c[CRC_W-1] ^ d[i];
            c  = {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_W'(`CRC_POLY) : '0);
        end
        return c;
    endfunction

    // split word and compare the four check bits
    wire logic [DATA_W-1:0] dat_w   = word_in[DATA_W+CRC_W-1:CRC_W];
    wire logic              match_w = (crc_calc(dat_w) == word_in[CRC_W-1:0]); // RULE10

    // bad words are dropped so a corrupted word never reaches the aux pins
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            data_out <= '0;
            ok_out   <= 1'b0;
            err_out  <= 1'b0;
        end else begin
            ok_out  <= valid_in & match_w;
            err_out <= valid_in & ~match_w; // RULE10
            if (valid_in && match_w) begin
                data_out <= dat_w;
            end
        end
    end

endmodule

// *** src/camlink_ser.sv ***
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "camlink_regs.svh"
module camlink_ser
    import camlink_pkg::*;
#(
    parameter int PCLK_LOSS_CYC = `PCLK_LOSS_CYC,
    parameter int LOCK_EDGES    = `LOCK_EDGES,
    parameter int INT_OSC_DIV   = `INT_OSC_DIV
) (
    input  wire logic                    mclk_in,
    input  wire logic                    rst_in,
    input  wire logic                    power_down_n_in,
    input  wire logic                    pclk_in,
    input  wire logic [11:0]             pix_data_in,
    input  wire logic [1:0]              line_frame_sync_in,
    input  wire logic [`BC_WORD_W-1:0]   bc_word_in,
    input  wire logic                    bc_valid_in,
    input  wire logic                    aux_out_3_in,
    input  wire logic [7:0]              reg_addr_in,
    input  wire logic [7:0]              reg_wdata_in,
    input  wire logic                    reg_wr_in,
    input  wire logic                    reg_rd_in,
    output logic      [7:0]              reg_rdata_out,
    output logic      [`FRAME_W-1:0]     frame_out,
    output logic                         frame_valid_out,
    output logic      [3:0]              aux_output_out,
    output logic      [3:0]              aux_output_oe_out
);

    // software state
    logic [1:0]  clk_ctrl_r;
    logic [1:0]  mode_r;
    logic        ext_osc_r;
    logic [7:0]  ctrl_tx_r;
    logic [7:0]  aux_cfg_r;
    logic [7:0]  err_cnt_r;
    logic        err_seen_r;
    logic [7:0]  rdata_r;
    // link state
    src_t        state_r;
    src_t        state_nxt;
    logic        pclk_q_r;
    logic [7:0]  lost_cnt_r;
    logic [3:0]  lock_cnt_r;
    logic [3:0]  osc_cnt_r;
    logic [`ACC_W-1:0] acc_r;
    logic [5:0]  cnt_r;
    logic [15:0] lfsr_r;
    logic [15:0] lfsr_q_r;
    logic        disp_r;
    logic [2:0]  fidx_r;
    logic [`FRAME_W-1:0] frame_r;
    logic        frame_v_r;
    // aux pins
    logic [3:0]  aux_r;
    logic        aux3_q_r;
    logic        aux_div_r;
    logic [`BC_DATA_W-1:0] bc_data_w;
    logic        bc_ok_w;
    logic        crc_err_w;

    // back-channel checker
    bc_crc_check #(
        .DATA_W (`BC_DATA_W),
        .CRC_W  (`CRC_W)
    ) u_bc (
        .clk_in   (mclk_in),
        .rst_in   (rst_in),
        .word_in  (bc_word_in),
        .valid_in (bc_valid_in),
        .data_out (bc_data_w),
        .ok_out   (bc_ok_w),
        .err_out  (crc_err_w)
    );

    // register strobes
    wire logic wr_clk_w  = reg_wr_in && (reg_addr_in == `REG_CLK_CTRL);
    wire logic wr_mode_w = reg_wr_in && (reg_addr_in == `REG_MODE);
    wire logic wr_ctl_w  = reg_wr_in && (reg_addr_in == `REG_CTRL_TX);
    wire logic wr_aux_w  = reg_wr_in && (reg_addr_in == `REG_AUX_CFG);
    wire logic wr_errb_w = reg_wr_in && (reg_addr_in == `REG_CRC_ERR_B);

    // mode decode; the unused code falls back to 12-bit low
    wire mode_t mode_w = (mode_r == `MODE_C_10B)  ? MODE_10B  :
                         (mode_r == `MODE_C_12HF) ? MODE_12HF : MODE_12LF;
    wire logic [5:0] p_w   = (mode_w == MODE_10B)  ? `PAY_10B  :
                             (mode_w == MODE_12HF) ? `PAY_12HF : `PAY_12LF; // RULE6
    wire logic [5:0] pix_w = (mode_w == MODE_10B) ? `PIX_10_W : `PIX_12_W; // RULE4
    // 10-bit mode drops the two top data bits
    wire logic [13:0] pix_word_w = (mode_w == MODE_10B) ?
        {2'b00, line_frame_sync_in, pix_data_in[9:0]} :  // RULE4
        {line_frame_sync_in, pix_data_in};               // RULE2 RULE3

    // pixel clock edges; inputs are synchronous so no synchroniser
    wire logic rise_w = pclk_in & ~pclk_q_r;
    wire logic fall_w = ~pclk_in & pclk_q_r;
    wire logic edge_w = rise_w | fall_w;
    wire logic cap_w  = clk_ctrl_r[`BIT_EDGE] ? rise_w : fall_w; // RULE15 RULE19
    wire logic lost_w = (lost_cnt_r == 8'(PCLK_LOSS_CYC - 1));
    wire logic hold_w = clk_ctrl_r[`BIT_OSC_HOLD];

    // bit accumulator: pixels go in, payload slices come out
    wire logic take_w = (state_r == SRC_PIXEL) && cap_w;
    wire logic [`ACC_W-1:0] acc_a_w = take_w ?
        (acc_r | ({34'h0, pix_word_w} << cnt_r)) : acc_r;
    wire logic [5:0] cnt_a_w = take_w ? 6'(cnt_r + pix_w) : cnt_r;
    wire logic emit_pix_w = (state_r == SRC_PIXEL) && (cnt_a_w >= p_w); // RULE6
    wire logic osc_tick_w = ((state_r == SRC_INTERNAL) || (state_r == SRC_LOCKING))
                            && (osc_cnt_r == 4'h0);
    wire logic emit_w = emit_pix_w | osc_tick_w;
    wire logic [`ACC_W-1:0] acc_n_w = emit_pix_w ? (acc_a_w >> p_w) : acc_a_w;
    wire logic [5:0] cnt_n_w = emit_pix_w ? 6'(cnt_a_w - p_w) : cnt_a_w;

    // frame build; internal-oscillator frames carry an all-zero payload
    wire logic [`PAY_W-1:0] mask_w = ~({`PAY_W{1'b1}} << p_w);
    wire logic [`PAY_W-1:0] pay_w  = emit_pix_w ? (acc_a_w[`PAY_W-1:0] & mask_w) : '0;
    wire logic ctl_w = ctrl_tx_r[fidx_r]; // RULE8
    wire logic par_w = ^{pay_w, ctl_w}; // RULE9 RULE21
    wire logic [`SCR_W-1:0] raw_w = {par_w, ctl_w, 1'b1, pay_w}; // RULE1
    wire logic [`SCR_W-1:0] scr_w = raw_w ^ {lfsr_r[10:0], lfsr_r}; // RULE7
    wire logic heavy_w = ($countones(scr_w) > `HALF_W);
    // invert when the word would push disparity further the same way
    wire logic inv_w = (heavy_w == disp_r); // RULE7
    wire logic [`FRAME_W-1:0] frame_nxt = {inv_w, inv_w ? ~scr_w : scr_w};
    wire logic [15:0] lfsr_nxt = {lfsr_r[14:0],
                                  lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};

    // error counter clears on power-down and on loss of lock
    wire logic clr_err_w = ~power_down_n_in || ((state_r == SRC_PIXEL) && lost_w); // RULE22

    // link state: fall back to internal oscillator, relock on pixel clock
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            SRC_DOWN: begin
                state_nxt = SRC_INTERNAL;
            end
            SRC_INTERNAL: begin
                if (edge_w && !hold_w) begin
                    state_nxt = SRC_LOCKING; // RULE20
                end
            end
            SRC_LOCKING: begin
                if (lost_w || hold_w) begin
                    state_nxt = SRC_INTERNAL;
                end else if (edge_w && (lock_cnt_r == 4'(LOCK_EDGES - 1))) begin
                    state_nxt = SRC_PIXEL; // RULE17
                end
            end
            SRC_PIXEL: begin
                if (lost_w || hold_w) begin
                    state_nxt = SRC_INTERNAL; // RULE17 RULE20
                end
            end
        endcase
        if (!power_down_n_in) begin
            state_nxt = SRC_DOWN; // RULE16
        end
    end

    // state and pixel clock watch
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r    <= SRC_DOWN;
            pclk_q_r   <= 1'b0;
            lost_cnt_r <= 8'h00;
        end else begin
            state_r    <= state_nxt;
            pclk_q_r   <= pclk_in;
            lost_cnt_r <= (edge_w || lost_w) ? 8'h00 : 8'(lost_cnt_r + 8'h01);
        end
    end

    // lock edge count and internal oscillator divider
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            lock_cnt_r <= 4'h0;
            osc_cnt_r  <= 4'h0;
        end else begin
            lock_cnt_r <= (state_r != SRC_LOCKING) ? 4'h0 :
                          edge_w ? 4'(lock_cnt_r + 4'h1) : lock_cnt_r;
            osc_cnt_r  <= (osc_cnt_r == 4'h0) ? 4'(INT_OSC_DIV - 1) :
                          4'(osc_cnt_r - 4'h1);
        end
    end

    // accumulator restarts on every relock so frames align to pixels
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            acc_r <= '0;
            cnt_r <= 6'h00;
        end else if (state_r != SRC_PIXEL) begin
            acc_r <= '0;
            cnt_r <= 6'h00;
        end else begin
            acc_r <= acc_n_w;
            cnt_r <= cnt_n_w;
        end
    end

    // scrambler, disparity and control bit index advance per frame
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            lfsr_r   <= `LFSR_SEED;
            lfsr_q_r <= `LFSR_SEED;
            disp_r   <= 1'b0;
            fidx_r   <= 3'h0;
        end else if (emit_w) begin
            lfsr_r   <= lfsr_nxt;
            lfsr_q_r <= lfsr_r;
            disp_r   <= heavy_w ^ inv_w; // RULE7
            fidx_r   <= 3'(fidx_r + 3'h1);
        end
    end

    // frame output; power-down parks the line high
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            frame_r   <= `FRAME_IDLE;
            frame_v_r <= 1'b0;
        end else if (!power_down_n_in) begin
            frame_r   <= `FRAME_IDLE; // RULE16
            frame_v_r <= 1'b0;
        end else begin
            frame_v_r <= emit_w;
            if (emit_w) begin
                frame_r <= frame_nxt;
            end
        end
    end

    // configuration registers
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            clk_ctrl_r <= `CLK_CTRL_RST;
            mode_r     <= `MODE_RST;
            ext_osc_r  <= 1'b0;
            ctrl_tx_r  <= `CTRL_TX_RST;
            aux_cfg_r  <= `AUX_CFG_RST;
        end else begin
            if (wr_clk_w) clk_ctrl_r <= reg_wdata_in[1:0]; // RULE19
            if (wr_mode_w) begin
                mode_r    <= reg_wdata_in[1:0];
                ext_osc_r <= reg_wdata_in[`BIT_EXT_OSC];
            end
            if (wr_ctl_w) ctrl_tx_r <= reg_wdata_in;
            if (wr_aux_w) aux_cfg_r <= reg_wdata_in;
        end
    end

    // crc error counter saturates; sticky flag keeps set over clear
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            err_cnt_r  <= 8'h00;
            err_seen_r <= 1'b0;
        end else begin
            if (clr_err_w) begin
                err_cnt_r <= 8'h00; // RULE22
            end else if (crc_err_w && (err_cnt_r != `CNT_MAX)) begin
                err_cnt_r <= 8'(err_cnt_r + 8'h01); // RULE10
            end
            err_seen_r <= crc_err_w |
                          (err_seen_r & ~(wr_errb_w & reg_wdata_in[`BIT_ERR_SEEN]));
        end
    end

    // aux pins: remote mirror or local value; ext osc takes pins 2 and 3
    wire logic aux3_rise_w = aux_out_3_in & ~aux3_q_r;
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            aux_r     <= 4'h0;
            aux3_q_r  <= 1'b0;
            aux_div_r <= 1'b0;
        end else begin
            aux3_q_r  <= aux_out_3_in;
            aux_div_r <= ext_osc_r ? (aux_div_r ^ aux3_rise_w) : 1'b0; // RULE13
            for (int i = 0; i < 4; i++) begin
                // no filtering: each good word lands next cycle
                aux_r[i] <= aux_cfg_r[i] ? bc_data_w[i] : aux_cfg_r[4+i]; // RULE12 RULE14 RULE18
            end
        end
    end
    assign aux_output_out    = ext_osc_r ? {1'b0, aux_div_r, aux_r[1:0]} : aux_r; // RULE13
    assign aux_output_oe_out = ext_osc_r ? 4'h7 : 4'hf; // RULE13

    // read mux; unmapped addresses read zero
    wire logic [7:0] status_w = {4'h0, ext_osc_r, state_r == SRC_PIXEL,
                                 state_r == SRC_INTERNAL, power_down_n_in};
    wire logic [7:0] rd_mux_w =
        (reg_addr_in == `REG_CLK_CTRL)  ? {6'h00, clk_ctrl_r} :
        (reg_addr_in == `REG_MODE)      ? {5'h00, ext_osc_r, mode_r} :
        (reg_addr_in == `REG_CTRL_TX)   ? ctrl_tx_r :
        (reg_addr_in == `REG_CTRL_RX)   ? {4'h0, bc_data_w[7:4]} :
        (reg_addr_in == `REG_CRC_ERR_A) ? err_cnt_r : // RULE11
        (reg_addr_in == `REG_CRC_ERR_B) ? {6'h00, err_cnt_r == `CNT_MAX, err_seen_r} :
        (reg_addr_in == `REG_STATUS)    ? status_w :
        (reg_addr_in == `REG_AUX_CFG)   ? aux_cfg_r : 8'h00;
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= reg_rd_in ? rd_mux_w : 8'h00;
        end
    end

    assign reg_rdata_out   = rdata_r;
    assign frame_out       = frame_r;
    assign frame_valid_out = frame_v_r;

    // checks; helper undoes scrambling and inversion of the sent frame
    localparam int AUX_SKEW_LIM = `AUX_SKEW_CYC;
    wire logic [`SCR_W-1:0] desc_w = (frame_r[`F_INV] ? ~frame_r[`SCR_W-1:0]
                                      : frame_r[`SCR_W-1:0]) ^ {lfsr_q_r[10:0], lfsr_q_r};
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    AST_PD_IDLE: assert property (!power_down_n_in |=> // RULE16
        (frame_out == `FRAME_IDLE) && !frame_valid_out)
        else $error("line not parked high in power-down");
    AST_MARK: assert property (frame_valid_out |-> desc_w[`F_MARK]) // RULE1
        else $error("frame marker bit lost");
    AST_PARITY: assert property (frame_valid_out |-> (^desc_w) == 1'b1) // RULE9
        else $error("frame parity wrong");
    AST_DC: assert property (frame_valid_out |-> // RULE7
        (($countones(frame_out[`SCR_W-1:0]) > `HALF_W) != $past(disp_r)))
        else $error("disparity grew");
    AST_ACC: assert property (state_r == SRC_PIXEL |-> cnt_r < p_w) // RULE6
        else $error("payload backlog");
    AST_EDGE: assert property (state_r == SRC_PIXEL && rise_w && // RULE15
        !clk_ctrl_r[`BIT_EDGE] && state_nxt == SRC_PIXEL |=> cnt_r == $past(cnt_r))
        else $error("captured on wrong edge");
    AST_CRC_CNT: assert property (crc_err_w && !clr_err_w && // RULE10
        err_cnt_r != `CNT_MAX |=> err_cnt_r == $past(err_cnt_r) + 8'h01)
        else $error("crc error not counted");
    AST_SAT: assert property (err_cnt_r == `CNT_MAX && !clr_err_w |=> // RULE22
        err_cnt_r == `CNT_MAX)
        else $error("counter wrapped");
    AST_CLR: assert property (!power_down_n_in |=> err_cnt_r == 8'h00) // RULE22
        else $error("counter kept in power-down");
    AST_RD: assert property (reg_rd_in && reg_addr_in == `REG_CRC_ERR_A |=> // RULE11
        reg_rdata_out == $past(err_cnt_r))
        else $error("count read wrong");
    AST_MIRROR: assert property (!ext_osc_r && aux_cfg_r[0] |=> // RULE12
        aux_output_out[0] == $past(bc_data_w[0]))
        else $error("remote state not mirrored");
    AST_SKEW: assert property ($rose(bc_data_w[1]) && aux_cfg_r[1] && // RULE18
        !ext_osc_r && !wr_aux_w |-> ##[1:AUX_SKEW_LIM] aux_output_out[1])
        else $error("aux edge late");
    AST_EXT: assert property (ext_osc_r |-> !aux_output_oe_out[3] && // RULE13
        aux_output_out[2] == aux_div_r)
        else $error("ext osc pins wrong");
    AST_HOLD: assert property (state_r == SRC_INTERNAL && hold_w && // RULE20
        power_down_n_in |=> state_r == SRC_INTERNAL)
        else $error("left internal osc while held");
    AST_FALLBACK: assert property (state_r == SRC_PIXEL && lost_w && // RULE17
        power_down_n_in |=> state_r == SRC_INTERNAL)
        else $error("no fallback on lost clock");

    CV_LOCK: cover property (state_r == SRC_LOCKING ##1 state_r == SRC_PIXEL);
    CV_10B: cover property (mode_w == MODE_10B && emit_pix_w);
    CV_HF: cover property (mode_w == MODE_12HF && emit_pix_w ##[1:8] emit_pix_w);
    CV_CRC: cover property (crc_err_w && err_cnt_r == `CNT_MAX);

endmodule

// *** test/remote_des_model.sv ***
`timescale 1ns/1ps
`include "camlink_regs.svh"
module remote_des_model (
    input  wire logic                  mclk_in,
    input  wire logic [`FRAME_W-1:0]   frame_in,
    input  wire logic                  frame_valid_in,
    output logic      [`BC_WORD_W-1:0] bc_word_out,
    output logic                       bc_valid_out
);
    int frames = 0;

    initial begin
        bc_word_out = '0;
        bc_valid_out = 1'b0;
    end

    // frame count lets the bench judge the frame rate per mode
    always @(posedge mclk_in) begin
        if (frame_valid_in) begin
            frames <= frames + 1;
        end
    end

    // crc-4, x^4+x+1, zero start, msb first
    function automatic logic [3:0] crc4(input logic [7:0] d);
        logic [3:0] c;
        logic       fb;
        c = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            fb = d[i] ^ c[3];
            c = {c[2:0], 1'b0} ^ (fb ? 4'h3 : 4'h0);
        end
        return c;
    endfunction

    // one word; bad flips a crc bit; idle word is inverted so stale data never matches
    task automatic send(input logic [7:0] d, input logic bad);
        @(posedge mclk_in);
        bc_word_out <= {d, crc4(d) ^ {3'h0, bad}};
        bc_valid_out <= 1'b1;
        @(posedge mclk_in);
        bc_valid_out <= 1'b0;
        bc_word_out <= ~{d, crc4(d)};
    endtask
endmodule

// *** test/camera_link_serializer_core_tb_top.sv ***
`timescale 1ns/1ps
`include "camlink_regs.svh"
`define CHK(got, exp) begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
        failures++; \
        $display("wrong value at %0t: got %h want %h", $time, got, exp); \
    end \
end
module camera_link_serializer_core_tb_top;
    logic                   mclk_in, rst_in, power_down_n_in, pclk_in, pclk_run, aux3, a2;
    logic [11:0]            pix_data_in;
    logic [1:0]             line_frame_sync_in, pdiv;
    logic [`BC_WORD_W-1:0]  bc_word;
    logic                   bc_valid, reg_wr_in, reg_rd_in, frame_valid_out;
    logic [7:0]             reg_addr_in, reg_wdata_in, reg_rdata_out;
    logic [`FRAME_W-1:0]    frame_out;
    logic [3:0]             aux_output_out, aux_output_oe_out;
    int                     failures = 0, n_checks = 0, cyc = 0;

    camlink_ser #(.PCLK_LOSS_CYC(16), .LOCK_EDGES(4), .INT_OSC_DIV(2)) DUT (
        .mclk_in(mclk_in), .rst_in(rst_in), .power_down_n_in(power_down_n_in),
        .pclk_in(pclk_in), .pix_data_in(pix_data_in), .line_frame_sync_in(line_frame_sync_in),
        .bc_word_in(bc_word), .bc_valid_in(bc_valid), .aux_out_3_in(aux3),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .frame_out(frame_out),
        .frame_valid_out(frame_valid_out), .aux_output_out(aux_output_out),
        .aux_output_oe_out(aux_output_oe_out));
    remote_des_model partner (.mclk_in(mclk_in), .frame_in(frame_out),
        .frame_valid_in(frame_valid_out), .bc_word_out(bc_word), .bc_valid_out(bc_valid));

    initial begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end

    // pixel clock at a quarter of mclk; sync lines move every 16 pixels at most
    always @(posedge mclk_in) begin
        if (pclk_run) begin
            pdiv <= pdiv + 2'h1;
            pclk_in <= pdiv[1];
            if (pdiv == 2'h3) begin
                pix_data_in <= pix_data_in + 12'h001;
                line_frame_sync_in <= pix_data_in[5:4];
            end
        end
    end

    // hang guard, far above the thousand or so cycles the run needs
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic note(input string s);
        $display("test %s done", s);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge mclk_in);
        @(negedge mclk_in);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        @(negedge mclk_in);
        `CHK(reg_rdata_out, exp)
    endtask

    // relock in a mode, then count frames over 24 pixels (96 mclk)
    task automatic lock_mode(input logic [7:0] m, input int exp);
        int start;
        @(posedge mclk_in);
        power_down_n_in <= 1'b0;
        wr(8'h05, m);
        power_down_n_in <= 1'b1;
        settle(40);
        rd(8'h0c, 8'h05);
        @(posedge pclk_in);
        @(negedge mclk_in);
        start = partner.frames;
        repeat (96) @(negedge mclk_in);
        `CHK(partner.frames - start, exp)
        note("mode frame rate");
    endtask

    // one rising edge on the oscillator input
    task automatic aux_pulse();
        @(posedge mclk_in);
        aux3 <= 1'b1;
        repeat (3) @(posedge mclk_in);
        aux3 <= 1'b0;
        settle(3);
    endtask

    initial begin
        rst_in = 1'b1;
        power_down_n_in = 1'b1;
        {pclk_in, pclk_run, aux3, reg_wr_in, reg_rd_in} = 5'h00;
        {pdiv, line_frame_sync_in, pix_data_in} = 16'h0000;
        {reg_addr_in, reg_wdata_in} = 16'h0000;
        repeat (16) @(posedge mclk_in);
        rst_in <= 1'b0;
        rd(8'h03, 8'h01);
        rd(8'h0d, 8'h0f);
        rd(8'h0a, 8'h00);
        rd(8'h20, 8'h00);
        rd(8'h0c, 8'h03);
        wr(8'h06, 8'h5a);
        rd(8'h06, 8'h5a);
        note("reset values");
        wr(8'h03, 8'h03);
        pclk_run <= 1'b1;
        settle(40);
        rd(8'h0c, 8'h03);
        wr(8'h03, 8'h01);
        note("oscillator hold");
        lock_mode(8'h00, 24);
        lock_mode(8'h01, 16);
        wr(8'h03, 8'h00);
        lock_mode(8'h02, 12);
        repeat (3) partner.send(8'h3c, 1'b1);
        rd(8'h0a, 8'h03);
        rd(8'h0b, 8'h01);
        wr(8'h0b, 8'h01);
        rd(8'h0b, 8'h00);
        partner.send(8'ha7, 1'b0);
        settle(3);
        `CHK(aux_output_out, 4'h7)
        rd(8'h07, 8'h0a);
        rd(8'h0a, 8'h03);
        wr(8'h0d, 8'h32);
        settle(2);
        `CHK(aux_output_out, 4'h3)
        note("back channel");
        @(posedge mclk_in);
        pclk_run <= 1'b0;
        settle(40);
        rd(8'h0a, 8'h00);
        rd(8'h0c, 8'h03);
        repeat (256) partner.send(8'h00, 1'b1);
        rd(8'h0a, 8'hff);
        rd(8'h0b, 8'h03);
        @(posedge mclk_in);
        power_down_n_in <= 1'b0;
        settle(3);
        `CHK(frame_out, `FRAME_IDLE)
        `CHK(frame_valid_out, 1'b0)
        rd(8'h0a, 8'h00);
        note("saturation and power down");
        @(posedge mclk_in);
        power_down_n_in <= 1'b1;
        wr(8'h05, 8'h04);
        settle(2);
        `CHK(aux_output_oe_out, 4'h7)
        a2 = aux_output_out[2];
        aux_pulse();
        `CHK(aux_output_out[2], ~a2)
        aux_pulse();
        `CHK(aux_output_out[2], a2)
        note("external oscillator");
        end_sim();
    end
endmodule
